/* File: core/cgen_consts.vh */
// constants for the clock generator block
`ifndef CGEN_CONSTS_VH
`define CGEN_CONSTS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CGEN_OFS_CTRL1 8'h00
`define CGEN_OFS_CTRL2 8'h04
`define CGEN_OFS_TRIM 8'h08
`define CGEN_OFS_STAT 8'h0C
// ----------------------------------------
// generator_control_one fields
// ----------------------------------------
`define CGEN_C1_CLKS_HI 7
`define CGEN_C1_CLKS_LO 6
`define CGEN_C1_REFERENCE_DIVIDER_SEL_HI 5
`define CGEN_C1_REFERENCE_DIVIDER_SEL_LO 3
`define CGEN_C1_IREFS 2
`define CGEN_C1_PLLS 1
`define CGEN_C1_LP 0
// ----------------------------------------
// generator_control_two fields
// ----------------------------------------
`define CGEN_C2_OUTPUT_DIVIDER_SEL_HI 7
`define CGEN_C2_OUTPUT_DIVIDER_SEL_LO 6
`define CGEN_C2_RANGE 5
`define CGEN_C2_HGO 4
`define CGEN_C2_CRYSTAL_REFERENCE_SEL 2
`define CGEN_C2_EXTERNAL_REFERENCE_ON 1
`define CGEN_C2_MASK 8'hF6
// ----------------------------------------
// generator_status_control fields
// ----------------------------------------
`define CGEN_SC_FINE_PERIOD_ADJUST 0
`define CGEN_SC_OSCILLATOR_READY_FLAG 1
`define CGEN_SC_CLKST_HI 3
`define CGEN_SC_CLKST_LO 2
`define CGEN_SC_LOOP_MULTIPLIER_SEL_HI 7
`define CGEN_SC_LOOP_MULTIPLIER_SEL_LO 4
// ----------------------------------------
// reset values
// ----------------------------------------
`define CGEN_RST_CTRL1 8'h04
`define CGEN_RST_CTRL2 8'h40
`define CGEN_RST_TRIM 8'h80
`define CGEN_RST_FINE_PERIOD_ADJUST 1'h0
`define CGEN_RST_LOOP_MULTIPLIER_SEL 4'h1
// ----------------------------------------
// clock source select codes
// ----------------------------------------
`define CGEN_SRC_LOOP 2'h0
`define CGEN_SRC_INT 2'h1
`define CGEN_SRC_EXT 2'h2
// ----------------------------------------
// loop figures
// ----------------------------------------
`define CGEN_FLL_MULT 11'h400
`define CGEN_ONE8 8'h01
`define CGEN_ONE4 4'h1
`endif

/* File: core/cgen_pulse_div.v */
// divides a stream of one-cycle pulses by a programmable ratio
`timescale 1ns/100ps
`default_nettype none
module cgen_pulse_div #(
    parameter W = 8
) (
    input wire mclk,
    input wire arst_n,
    input wire clr,
    input wire pulse_in,
    input wire [W-1:0] ratio,
    output reg pulse_out
);
    reg [W-1:0] cnt_r;
    wire [W-1:0] cnt_inc = cnt_r + {{(W-1){1'b0}}, 1'b1};

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= {W{1'b0}};
            pulse_out <= 1'b0;
        end else if (clr) begin
            cnt_r <= {W{1'b0}};
            pulse_out <= 1'b0;
        end else begin
            pulse_out <= 1'b0;
            if (pulse_in) begin
                if (cnt_inc >= ratio) begin
                    cnt_r <= {W{1'b0}};
                    pulse_out <= 1'b1;
                end else begin
                    cnt_r <= cnt_inc;
                end
            end
        end
    end
endmodule // cgen_pulse_div
`default_nettype wire

/* File: core/cgen_ref_osc.v */
// internal reference: one pulse per half period, period set by trim
`timescale 1ns/100ps
`default_nettype none
module cgen_ref_osc #(
    parameter BASE = 10'd64
) (
    input wire mclk,
    input wire arst_n,
    input wire [7:0] trim,
    input wire fine,
    output reg half_pulse
);
    reg [9:0] cnt_r;
    // binary weighted trim, fine bit as lsb; larger value, longer period
    wire [9:0] half_len = BASE + {1'b0, trim, fine};

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= 10'h000;
            half_pulse <= 1'b0;
        end else if (cnt_r + 10'h001 >= half_len) begin
            cnt_r <= 10'h000;
            half_pulse <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 10'h001;
            half_pulse <= 1'b0;
        end
    end
endmodule // cgen_ref_osc
`default_nettype wire

/* File: core/cgen_top.v */
// clock generator: reference select, loops, dividers and apb registers
`timescale 1ns/100ps
`default_nettype none
`include "cgen_consts.vh"
module cgen_top #(
    parameter OSC_EDGES = 16'd1024,
    parameter LOOP_MULTIPLIER_SEL_STEP = 4'd4,
    parameter IREF_BASE = 10'd64
) (
    input wire mclk,
    input wire arst_n,
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire ext_ref_in,
    output reg generator_output_clock,
    output reg bus_clk,
    output wire external_reference_on,
    output wire oscillator_high_gain,
    output wire crystal_reference_sel,
    output wire osc_range_high
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [7:0] ctrl1_r;
    reg [7:0] ctrl2_r;
    reg [7:0] internal_reference_trim_r;
    reg fine_period_adjust_r;
    reg [3:0] loop_multiplier_sel_r;
    reg oscillator_ready_flag_r;
    reg [15:0] osc_cnt_r;
    reg [1:0] sel_r;
    reg ext_d_r;
    reg [23:0] per_cnt_r;
    reg [23:0] per_r;
    reg [23:0] acc_r;
    reg loop_pulse_r;

    wire wr_en = psel & penable & pwrite;
    wire hit_c1 = (paddr == `CGEN_OFS_CTRL1);
    wire hit_c2 = (paddr == `CGEN_OFS_CTRL2);
    wire hit_tr = (paddr == `CGEN_OFS_TRIM);
    wire hit_sc = (paddr == `CGEN_OFS_STAT);
    wire hit = hit_c1 | hit_c2 | hit_tr | hit_sc;

    // ----------------------------------------
    // apb answer
    // ----------------------------------------
    // zero wait states, unmapped offsets answer with an error
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;

    // ----------------------------------------
    // field decode
    // ----------------------------------------
    wire [1:0] clks = ctrl1_r[`CGEN_C1_CLKS_HI:`CGEN_C1_CLKS_LO];
    wire [2:0] reference_divider_sel = ctrl1_r[`CGEN_C1_REFERENCE_DIVIDER_SEL_HI:`CGEN_C1_REFERENCE_DIVIDER_SEL_LO];
    wire irefs = ctrl1_r[`CGEN_C1_IREFS];
    wire plls = ctrl1_r[`CGEN_C1_PLLS];
    wire low_power = ctrl1_r[`CGEN_C1_LP];
    wire [1:0] output_divider_sel = ctrl2_r[`CGEN_C2_OUTPUT_DIVIDER_SEL_HI:`CGEN_C2_OUTPUT_DIVIDER_SEL_LO];
    assign osc_range_high = ctrl2_r[`CGEN_C2_RANGE];
    assign oscillator_high_gain = ctrl2_r[`CGEN_C2_HGO];
    assign crystal_reference_sel = ctrl2_r[`CGEN_C2_CRYSTAL_REFERENCE_SEL];
    assign external_reference_on = ctrl2_r[`CGEN_C2_EXTERNAL_REFERENCE_ON];

    wire [7:0] r_ratio = `CGEN_ONE8 << reference_divider_sel;
    wire [3:0] b_ratio = `CGEN_ONE4 << output_divider_sel;
    wire [7:0] m_prod = {4'h0, loop_multiplier_sel_r} * {4'h0, LOOP_MULTIPLIER_SEL_STEP};
    wire [10:0] m_val = {3'h0, m_prod};

    // ----------------------------------------
    // apb register writes
    // ----------------------------------------
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            // reset in fll internal engaged, divider zero
            ctrl1_r <= `CGEN_RST_CTRL1;
            ctrl2_r <= `CGEN_RST_CTRL2;
            internal_reference_trim_r <= `CGEN_RST_TRIM;
            fine_period_adjust_r <= `CGEN_RST_FINE_PERIOD_ADJUST;
            loop_multiplier_sel_r <= `CGEN_RST_LOOP_MULTIPLIER_SEL;
        end else if (wr_en) begin
            if (hit_c1) begin
                ctrl1_r <= pwdata[7:0];
            end
            if (hit_c2) begin
                ctrl2_r <= pwdata[7:0] & `CGEN_C2_MASK;
            end
            // trim only ever loaded by software
            if (hit_tr) begin
                internal_reference_trim_r <= pwdata[7:0];
            end
            if (hit_sc) begin
                fine_period_adjust_r <= pwdata[`CGEN_SC_FINE_PERIOD_ADJUST];
                loop_multiplier_sel_r <= pwdata[`CGEN_SC_LOOP_MULTIPLIER_SEL_HI:`CGEN_SC_LOOP_MULTIPLIER_SEL_LO];
            end
        end
    end

    // ----------------------------------------
    // apb read data
    // ----------------------------------------
    always @* begin
        prdata = 32'h0000_0000;
        if (hit_c1) begin
            prdata[7:0] = ctrl1_r;
        end else if (hit_c2) begin
            prdata[7:0] = ctrl2_r;
        end else if (hit_tr) begin
            prdata[7:0] = internal_reference_trim_r;
        end else if (hit_sc) begin
            prdata[`CGEN_SC_LOOP_MULTIPLIER_SEL_HI:`CGEN_SC_LOOP_MULTIPLIER_SEL_LO] = loop_multiplier_sel_r;
            prdata[`CGEN_SC_CLKST_HI:`CGEN_SC_CLKST_LO] = sel_r;
            prdata[`CGEN_SC_OSCILLATOR_READY_FLAG] = oscillator_ready_flag_r;
            prdata[`CGEN_SC_FINE_PERIOD_ADJUST] = fine_period_adjust_r;
        end
    end

    // ----------------------------------------
    // reference sources
    // ----------------------------------------
    wire int_pulse;
    wire ext_div_pulse;
    wire b_pulse;
    wire switch_now;

    // fine bit adds one more step
    cgen_ref_osc #(
        .BASE(IREF_BASE)
    ) u_ref_osc (
        .mclk(mclk),
        .arst_n(arst_n),
        .trim(internal_reference_trim_r),
        .fine(fine_period_adjust_r),
        .half_pulse(int_pulse)
    );

    // each external edge is one half period
    wire ext_edge = (ext_ref_in ^ ext_d_r) & external_reference_on;

    cgen_pulse_div #(
        .W(8)
    ) u_reference_divider_sel (
        .mclk(mclk),
        .arst_n(arst_n),
        .clr(1'b0),
        .pulse_in(ext_edge),
        .ratio(r_ratio),
        .pulse_out(ext_div_pulse)
    );

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ext_d_r <= 1'b0;
        end else begin
            ext_d_r <= ext_ref_in;
        end
    end

    // ----------------------------------------
    // oscillator start-up
    // ----------------------------------------
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            osc_cnt_r <= 16'h0000;
            oscillator_ready_flag_r <= 1'b0;
        end else if (!external_reference_on) begin
            osc_cnt_r <= 16'h0000;
            oscillator_ready_flag_r <= 1'b0;
        end else if (ext_edge && !oscillator_ready_flag_r) begin
            if (osc_cnt_r + 16'h0001 >= OSC_EDGES) begin
                oscillator_ready_flag_r <= 1'b1;
            end
            osc_cnt_r <= osc_cnt_r + 16'h0001;
        end
    end

    // ----------------------------------------
    // frequency and phase locked loop
    // ----------------------------------------
    // pll always takes the external reference
    wire loop_ref = (plls | ~irefs) ? ext_div_pulse : int_pulse;
    wire [10:0] mult = plls ? m_val : `CGEN_FLL_MULT;
    wire [23:0] acc_sum = acc_r + {13'h0000, mult};
    wire loop_hit = (per_r != 24'h000000) && (acc_sum >= per_r);
    // surplus capped at one period so the sum never wraps
    wire [23:0] acc_left = acc_sum - per_r;

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            per_cnt_r <= 24'h000000;
            per_r <= 24'h000000;
            acc_r <= 24'h000000;
            loop_pulse_r <= 1'b0;
        end else if (low_power && (clks != `CGEN_SRC_LOOP)) begin
            per_cnt_r <= 24'h000000;
            per_r <= 24'h000000;
            acc_r <= 24'h000000;
            loop_pulse_r <= 1'b0;
        end else begin
            if (loop_ref) begin
                per_cnt_r <= 24'h000000;
                per_r <= per_cnt_r + 24'h000001;
            end else if (per_cnt_r != 24'hFFFFFF) begin
                per_cnt_r <= per_cnt_r + 24'h000001;
            end
            // output half periods at mult times the reference rate
            if (per_r == 24'h000000) begin
                acc_r <= 24'h000000;
            end else if (!loop_hit) begin
                acc_r <= acc_sum;
            end else if (acc_left >= per_r) begin
                acc_r <= per_r;
            end else begin
                acc_r <= acc_left;
            end
            loop_pulse_r <= loop_hit;
        end
    end

    // ----------------------------------------
    // source select and output divider
    // ----------------------------------------
    reg src_pulse;
    always @* begin
        case (sel_r)
            `CGEN_SRC_LOOP: src_pulse = loop_pulse_r;
            `CGEN_SRC_INT: src_pulse = int_pulse;
            `CGEN_SRC_EXT: src_pulse = ext_edge;
            default: src_pulse = 1'b0;
        endcase
    end

    cgen_pulse_div #(
        .W(4)
    ) u_output_divider_sel (
        .mclk(mclk),
        .arst_n(arst_n),
        .clr(switch_now),
        .pulse_in(src_pulse),
        .ratio(b_ratio),
        .pulse_out(b_pulse)
    );

    // swap only as a full high phase ends
    assign switch_now = b_pulse & generator_output_clock & (clks != sel_r);

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sel_r <= `CGEN_SRC_LOOP;
            generator_output_clock <= 1'b0;
        end else begin
            if (switch_now) begin
                sel_r <= clks;
            end
            if (b_pulse) begin
                generator_output_clock <= ~generator_output_clock;
            end
        end
    end

    // ----------------------------------------
    // bus clock
    // ----------------------------------------
    // bus clock toggles on each output rise
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            bus_clk <= 1'b0;
        end else if (b_pulse && !generator_output_clock) begin
            bus_clk <= ~bus_clk;
        end
    end
endmodule // cgen_top
`default_nettype wire

/* File: test/cgen_top_monitor.sv */
// checker for the clock generator block ports
`timescale 1ns/100ps
`default_nettype none
module cgen_top_monitor (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic generator_output_clock,
    input wire logic bus_clk,
    input wire logic external_reference_on,
    input wire logic oscillator_high_gain,
    input wire logic crystal_reference_sel,
    input wire logic osc_range_high
);
    // ----------------------------------------
    // helpers and assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    logic acc;
    logic map;
    logic [3:0] pins;
    assign acc = psel && penable;
    assign map = (paddr[1:0] == 2'h0) && (paddr < 8'h10);
    assign pins = {osc_range_high, oscillator_high_gain, crystal_reference_sel,
        external_reference_on};
    a_upper_zero: assert property (
        acc && !pwrite |-> prdata[31:8] == 24'h000000) else $error("upper read bits set");
    a_err_unmapped: assert property (
        acc && !map |-> pslverr) else $error("no error on unmapped access");
    a_err_mapped: assert property (
        acc && map |-> !pslverr && pready) else $error("bad answer on mapped access");
    a_c2_pins_follow: assert property (
        acc && pwrite && paddr == 8'h04 |=> pins == {$past(pwdata[5]), $past(pwdata[4]),
        $past(pwdata[2]), $past(pwdata[1])}) else $error("control pins miss write");
    a_c2_pins_hold: assert property (
        !(acc && pwrite && paddr == 8'h04) |=> $stable(pins)) else $error("control pins moved");
    a_c2_readback: assert property (
        psel && !pwrite && paddr == 8'h04 |-> (prdata[5:0] & 6'h3F) == {pins[3:2], 1'b0,
        pins[1:0], 1'b0}) else $error("control two read differs from pins");
    a_ready_needs_ext: assert property (
        psel && !pwrite && paddr == 8'h0C && prdata[1] |-> $past(external_reference_on))
        else $error("ready flag without reference");
    a_bus_follows: assert property (
        $rose(generator_output_clock) |-> ##[0:1] $changed(bus_clk)) else $error("bus missed rise");
    a_bus_still_low: assert property (
        !generator_output_clock && !$past(generator_output_clock) |-> $stable(bus_clk))
        else $error("bus moved while output low");
endmodule // cgen_top_monitor
bind cgen_top cgen_top_monitor cgen_top_monitor_inst (.mclk(mclk), .arst_n(arst_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .generator_output_clock(generator_output_clock), .bus_clk(bus_clk),
    .external_reference_on(external_reference_on), .oscillator_high_gain(oscillator_high_gain),
    .crystal_reference_sel(crystal_reference_sel), .osc_range_high(osc_range_high));
`default_nettype wire

/* File: test/cgen_top_tb_top.sv */
// testbench for the clock generator block
`timescale 1ns/100ps
`default_nettype none
module cgen_top_tb_top;
    // ----------------------------------------
    // wiring and tasks
    // ----------------------------------------
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] q;
    logic err;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, ext_ref_in, gen_clk, bus_clk, ref_on, hi_gain, xtal, rng_hi;
    int error_cnt = 0;
    int checks_done = 0;
    int n, gc, bc;
    logic pg, pb;
    always #2 mclk = ~mclk;
    cgen_top #(.OSC_EDGES(16'd4), .IREF_BASE(10'd8)) cgen_top_inst (.mclk(mclk),
        .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_ref_in(ext_ref_in), .generator_output_clock(gen_clk), .bus_clk(bus_clk),
        .external_reference_on(ref_on), .oscillator_high_gain(hi_gain),
        .crystal_reference_sel(xtal), .osc_range_high(rng_hi));
    cgen_xtal_model #(.HALF(6)) cgen_xtal_model_inst (.mclk(mclk), .run_en(ref_on),
        .ref_out(ext_ref_in));
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic hang;
        error_cnt++;
        $display("mismatch at %0t: timeout", $time);
        tally_and_finish();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge mclk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) begin
            if (++k > 50) begin
                hang();
            end
            @(posedge mclk);
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ee);
        apb(a, 1'b0, 32'h0);
        chk(q, e);
        chk({31'h0, err}, {31'h0, ee});
    endtask
    task automatic wait_lvl(input logic v);
        int k;
        k = 0;
        @(posedge mclk);
        while (gen_clk !== v) begin
            if (++k > 3000) begin
                hang();
            end
            @(posedge mclk);
        end
    endtask
    task automatic hi_len(input int e);
        int k;
        wait_lvl(1'b0);
        wait_lvl(1'b1);
        wait_lvl(1'b0);
        wait_lvl(1'b1);
        k = 1;
        @(posedge mclk);
        while (gen_clk === 1'b1 && k < 4000) begin
            k++;
            @(posedge mclk);
        end
        chk(k, e);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        rd(8'h00, 32'h04, 1'b0);
        rd(8'h04, 32'h40, 1'b0);
        rd(8'h08, 32'h80, 1'b0);
        rd(8'h0C, 32'h10, 1'b0);
        rd(8'h10, 32'h0, 1'b1);
        apb(8'h10, 1'b1, 32'hFF);
        rd(8'h08, 32'h80, 1'b0);
        repeat (1000) @(posedge mclk);
        pg = gen_clk;
        pb = bus_clk;
        gc = 0;
        bc = 0;
        for (int i = 0; i < 400; i++) begin
            @(posedge mclk);
            gc += (gen_clk !== pg);
            bc += (bus_clk !== pb);
            pg = gen_clk;
            pb = bus_clk;
        end
        chk(32'(gc > 20), 32'h1);
        chk(32'(gc >= 2 * bc - 3 && gc <= 2 * bc + 3), 32'h1);
        apb(8'h04, 1'b1, 32'hFF);
        rd(8'h04, 32'hF6, 1'b0);
        apb(8'h04, 1'b1, 32'h00);
        apb(8'h00, 1'b1, 32'h44);
        for (int t = 1; t <= 16; t = t * 4) begin
            apb(8'h08, 1'b1, 32'(t));
            hi_len(8 + 2 * t);
        end
        apb(8'h0C, 1'b1, 32'h11);
        hi_len(8 + 33);
        apb(8'h04, 1'b1, 32'h40);
        hi_len(2 * 41);
        apb(8'h04, 1'b1, 32'h36);
        n = 0;
        do begin
            apb(8'h0C, 1'b0, 32'h0);
            n++;
        end while (q[1] !== 1'b1 && n < 100);
        chk(q, 32'h17);
        // external bypass before pll engaged mode
        apb(8'h00, 1'b1, 32'h80);
        hi_len(6);
        apb(8'h04, 1'b1, 32'h76);
        hi_len(12);
        // divided reference spans a whole number of loop steps
        // pll engaged entered from external bypass
        apb(8'h00, 1'b1, 32'h1A);
        repeat (200) @(posedge mclk);
        hi_len(24);
        apb(8'h0C, 1'b1, 32'h21);
        repeat (200) @(posedge mclk);
        hi_len(12);
        rd(8'h0C, 32'h23, 1'b0);
        apb(8'h04, 1'b1, 32'h34);
        apb(8'h0C, 1'b0, 32'h0);
        chk({31'h0, q[1]}, 32'h0);
        tally_and_finish();
    end
endmodule // cgen_top_tb_top
`default_nettype wire

/* File: test/cgen_xtal_model.sv */
// external crystal model: toggles the reference line while enabled
`timescale 1ns/100ps
`default_nettype none
module cgen_xtal_model #(
    parameter int HALF = 6
) (
    input wire logic mclk,
    input wire logic run_en,
    output logic ref_out
);
    int cnt = 0;
    logic tog_r = 1'b0;
    assign ref_out = tog_r;
    always @(posedge mclk) begin
        if (!run_en) begin
            cnt <= 0;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            tog_r <= !tog_r;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule // cgen_xtal_model
`default_nettype wire
